/* verilog/dpl_defines.vh */
// Purpose: Shared constants for the dual synthesizer control latches
// Assumes: 24-bit serial words, select bits in the two lowest positions
// Notes: Included by bare name from the design files
`ifndef DPL_DEFINES_VH
`define DPL_DEFINES_VH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define DPL_WORD_W 24
`define DPL_SEL_HI 1
`define DPL_SEL_LO 0
`define DPL_SEL_IF_REF 2'h0
`define DPL_SEL_IF_FB 2'h1
`define DPL_SEL_RF_REF 2'h2
`define DPL_SEL_RF_FB 2'h3

// ----------------------------------------------------------------
// Reference latch fields
// ----------------------------------------------------------------
`define DPL_CUR_MSB 23
`define DPL_CUR_LSB 21
`define DPL_MODE_MSB 20
`define DPL_MODE_LSB 19
`define DPL_HIZ_BIT 18
`define DPL_SENSE_BIT 17
`define DPL_REF_MSB 15
`define DPL_REF_LSB 2

// ----------------------------------------------------------------
// Feedback latch fields
// ----------------------------------------------------------------
`define DPL_BOOST_BIT 23
`define DPL_SLEEP_BIT 22
`define DPL_PRESC_MSB 21
`define DPL_PRESC_LSB 20
`define DPL_PROG_MSB 19
`define DPL_PROG_LSB 8
`define DPL_SWAL_MSB 7
`define DPL_SWAL_LSB 2

// ----------------------------------------------------------------
// Status pin modes, code is {rf mode bits, if mode bits}
// ----------------------------------------------------------------
`define DPL_MODE_LOW 4'h0
`define DPL_MODE_LD_IF 4'h1
`define DPL_MODE_LD_RF 4'h2
`define DPL_MODE_LD_BOTH 4'h3
`define DPL_MODE_CR_IF 4'h4
`define DPL_MODE_CR_RF 4'h5
`define DPL_MODE_CR_BOTH 4'h6
`define DPL_MODE_FASTLOCK 4'h7

// ----------------------------------------------------------------
// Reset values and fixed settings
// ----------------------------------------------------------------
`define DPL_LATCH_RST 24'h000000
`define DPL_CUR_MAX 3'h7

`endif

/* verilog/dpl_sync.v */
// Purpose: Two-stage synchronizer with rising-edge detect per bit
// Assumes: Inputs are asynchronous to clk
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module dpl_sync #(
	parameter W = 5
) (
	input wire clk,
	input wire clk_en,
	input wire reset,
	input wire [W-1:0] async_in,
	output wire [W-1:0] level_out,
	output wire [W-1:0] rise_out
);

	reg [W-1:0] stage1_r;
	reg [W-1:0] stage2_r;
	reg [W-1:0] prev_r;

	// ----------------------------------------------------------------
	// Sampling
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (reset) begin
			stage1_r <= {W{1'b0}};
			stage2_r <= {W{1'b0}};
			prev_r <= {W{1'b0}};
		end else if (clk_en) begin
			stage1_r <= async_in;
			stage2_r <= stage1_r;
			prev_r <= stage2_r;
		end
	end

	assign level_out = stage2_r;
	assign rise_out = stage2_r & ~prev_r;

endmodule // dpl_sync

`default_nettype wire

/* verilog/dpl_control.v */
// Purpose: Serial word capture and control latches of a dual synthesizer
// Assumes: Host pins asynchronous to clk, serial clock well below clk/4
// Notes: Contract
// Contract
// - Select 0,0 loads IF reference latch with 14-bit divide value.
// - Select 0,1 loads IF feedback latch: 6-bit swallow, 12-bit programmable.
// - Select 1,0 loads RF reference latch with 14-bit divide value.
// - Select 1,1 loads RF feedback latch with gain, sleep, prescaler, counters.
// - Per-side polarity bit selects phase detector sense.
// - Per-side three-state bit at 1 puts charge pump in high impedance.
// - Per-side 3-bit current field in reference latch sets pump current.
// - Analog lock detect: status pin high with narrow low pulses when locked.
// - Combined lock detect shows lock only while both loops locked.
// - Counter reset modes hold counters and three-state pump per side.
// - On reset release feedback counter restarts aligned to reference counter.
// - Fastlock mode drives status pin low while RF gain bit is 1.
// - IF gain bit 1 forces max current and grounds fast-settle pin.
// - IF sleep with pump enabled: three-state first, then power down.
// - IF sleep with pump already three-state: power down at the strobe.
// - RF sleep with pump enabled: three-state first, then power down.
// - RF sleep with pump already three-state: power down at the strobe.
// - Power-down holds dividers in load state and isolates input section.
// - Reference input disabled only when both sides are powered down.
// - Shift register and latches keep working in every power-down mode.
// - Latching sleep 0 returns the side to operation at once.
// - Data sampled on serial clock rise, word latched on strobe rise.
// - RF fastlock lasts until the RF gain bit is written 0.
`timescale 1ns/100ps
`default_nettype none
`include "dpl_defines.vh"

module dpl_control (
	input wire clk,
	input wire reset,
	input wire clk_en,
	input wire serial_clk,
	input wire serial_in,
	input wire load_strobe,
	input wire if_pfd_active,
	input wire rf_pfd_active,
	output wire [13:0] if_reference_divider,
	output wire [5:0] if_swallow_count,
	output wire [11:0] if_program_count,
	output wire [1:0] if_prescale_sel,
	output wire if_detector_sense,
	output reg [2:0] if_pump_current,
	output reg if_pump_hiz,
	output reg if_counter_hold,
	output reg if_div_resync,
	output reg if_powered_down,
	output wire [13:0] rf_reference_divider,
	output wire [5:0] rf_swallow_count,
	output wire [11:0] rf_program_count,
	output wire [1:0] rf_prescale_sel,
	output wire rf_detector_sense,
	output reg [2:0] rf_pump_current,
	output reg rf_pump_hiz,
	output reg rf_counter_hold,
	output reg rf_div_resync,
	output reg rf_powered_down,
	output reg reference_input_disable,
	output reg multiplexed_status_pin,
	output reg fast_settle_switch_pin,
	output reg fast_settle_switch_oe,
	output reg outputs_active
);

	// ----------------------------------------------------------------
	// Power-down states
	// ----------------------------------------------------------------
	localparam [2:0] PD_RUN = 3'b001;
	localparam [2:0] PD_HIZ = 3'b010;
	localparam [2:0] PD_OFF = 3'b100;

	function [2:0] pd_next;
		input [2:0] state;
		input sleep;
		input hiz;
		begin
			case (state)
				PD_RUN: begin
					if (!sleep)
						pd_next = PD_RUN;
					else if (hiz)
						pd_next = PD_OFF;
					else
						pd_next = PD_HIZ;
				end
				PD_HIZ: begin
					pd_next = sleep ? PD_OFF : PD_RUN;
				end
				PD_OFF: begin
					pd_next = sleep ? PD_OFF : PD_RUN;
				end
				default: begin
					pd_next = PD_RUN;
				end
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronizers
	// ----------------------------------------------------------------
	wire [4:0] pin_level;
	wire [4:0] pin_rise;

	dpl_sync #(
		.W(5)
	) u_sync (
		.clk(clk),
		.clk_en(clk_en),
		.reset(reset),
		.async_in({rf_pfd_active, if_pfd_active, load_strobe, serial_clk, serial_in}),
		.level_out(pin_level),
		.rise_out(pin_rise)
	);

	wire serial_in_s = pin_level[0];
	wire sclk_rise = pin_rise[1];
	wire strobe_rise = pin_rise[2];
	wire if_act_s = pin_level[3];
	wire rf_act_s = pin_level[4];

	// ----------------------------------------------------------------
	// Shift register and latches
	// ----------------------------------------------------------------
	reg [`DPL_WORD_W-1:0] shift_r;
	reg [`DPL_WORD_W-1:0] if_ref_r;
	reg [`DPL_WORD_W-1:0] if_fb_r;
	reg [`DPL_WORD_W-1:0] rf_ref_r;
	reg [`DPL_WORD_W-1:0] rf_fb_r;
	reg [3:0] seen_r;

	wire latch_select_hi = shift_r[`DPL_SEL_HI];
	wire latch_select_lo = shift_r[`DPL_SEL_LO];

	always @(posedge clk) begin
		if (reset) begin
			shift_r <= `DPL_LATCH_RST;
			if_ref_r <= `DPL_LATCH_RST;
			if_fb_r <= `DPL_LATCH_RST;
			rf_ref_r <= `DPL_LATCH_RST;
			rf_fb_r <= `DPL_LATCH_RST;
			seen_r <= 4'h0;
		end else if (clk_en) begin
			if (sclk_rise) begin
				shift_r <= {shift_r[`DPL_WORD_W-2:0], serial_in_s};
			end
			if (strobe_rise) begin
				case ({latch_select_hi, latch_select_lo})
					`DPL_SEL_IF_REF: begin
						if_ref_r <= shift_r;
						seen_r[0] <= 1'b1;
					end
					`DPL_SEL_IF_FB: begin
						if_fb_r <= shift_r;
						seen_r[1] <= 1'b1;
					end
					`DPL_SEL_RF_REF: begin
						rf_ref_r <= shift_r;
						seen_r[2] <= 1'b1;
					end
					`DPL_SEL_RF_FB: begin
						rf_fb_r <= shift_r;
						seen_r[3] <= 1'b1;
					end
					default: begin
						seen_r <= seen_r;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Divider and setting fields
	// ----------------------------------------------------------------
	assign if_reference_divider = if_ref_r[`DPL_REF_MSB:`DPL_REF_LSB];
	assign rf_reference_divider = rf_ref_r[`DPL_REF_MSB:`DPL_REF_LSB];
	assign if_swallow_count = if_fb_r[`DPL_SWAL_MSB:`DPL_SWAL_LSB];
	assign if_program_count = if_fb_r[`DPL_PROG_MSB:`DPL_PROG_LSB];
	assign rf_swallow_count = rf_fb_r[`DPL_SWAL_MSB:`DPL_SWAL_LSB];
	assign rf_program_count = rf_fb_r[`DPL_PROG_MSB:`DPL_PROG_LSB];
	assign if_prescale_sel = if_fb_r[`DPL_PRESC_MSB:`DPL_PRESC_LSB];
	assign rf_prescale_sel = rf_fb_r[`DPL_PRESC_MSB:`DPL_PRESC_LSB];
	assign if_detector_sense = if_ref_r[`DPL_SENSE_BIT];
	assign rf_detector_sense = rf_ref_r[`DPL_SENSE_BIT];

	wire if_pump_hiz_bit = if_ref_r[`DPL_HIZ_BIT];
	wire rf_pump_hiz_bit = rf_ref_r[`DPL_HIZ_BIT];
	wire if_pump_boost = if_fb_r[`DPL_BOOST_BIT];
	wire rf_pump_boost = rf_fb_r[`DPL_BOOST_BIT];
	wire if_sleep = if_fb_r[`DPL_SLEEP_BIT];
	wire rf_sleep = rf_fb_r[`DPL_SLEEP_BIT];
	wire [3:0] mode = {rf_ref_r[`DPL_MODE_MSB:`DPL_MODE_LSB],
		if_ref_r[`DPL_MODE_MSB:`DPL_MODE_LSB]};

	// ----------------------------------------------------------------
	// Power-down sequencing
	// ----------------------------------------------------------------
	reg [2:0] if_pd_r;
	reg [2:0] rf_pd_r;
	wire [2:0] if_pd_nxt = pd_next(if_pd_r, if_sleep, if_pump_hiz_bit);
	wire [2:0] rf_pd_nxt = pd_next(rf_pd_r, rf_sleep, rf_pump_hiz_bit);

	always @(posedge clk) begin
		if (reset) begin
			if_pd_r <= PD_RUN;
			rf_pd_r <= PD_RUN;
		end else if (clk_en) begin
			if_pd_r <= if_pd_nxt;
			rf_pd_r <= rf_pd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Output decode
	// ----------------------------------------------------------------
	reg [2:0] if_pump_current_nxt;
	reg [2:0] rf_pump_current_nxt;
	reg if_pump_hiz_nxt;
	reg rf_pump_hiz_nxt;
	reg if_counter_hold_nxt;
	reg rf_counter_hold_nxt;
	reg if_cnt_rst;
	reg rf_cnt_rst;
	reg status_nxt;
	reg active_nxt;

	always @* begin
		active_nxt = &seen_r;
		if_cnt_rst = (mode == `DPL_MODE_CR_IF) || (mode == `DPL_MODE_CR_BOTH);
		rf_cnt_rst = (mode == `DPL_MODE_CR_RF) || (mode == `DPL_MODE_CR_BOTH);
		if_pump_current_nxt = if_pump_boost ? `DPL_CUR_MAX :
			if_ref_r[`DPL_CUR_MSB:`DPL_CUR_LSB];
		rf_pump_current_nxt = rf_pump_boost ? `DPL_CUR_MAX :
			rf_ref_r[`DPL_CUR_MSB:`DPL_CUR_LSB];
		if_pump_hiz_nxt = if_pump_hiz_bit || if_cnt_rst || (if_pd_nxt != PD_RUN) ||
			!active_nxt;
		rf_pump_hiz_nxt = rf_pump_hiz_bit || rf_cnt_rst || (rf_pd_nxt != PD_RUN) ||
			!active_nxt;
		if_counter_hold_nxt = if_cnt_rst || (if_pd_nxt == PD_OFF) || !active_nxt;
		rf_counter_hold_nxt = rf_cnt_rst || (rf_pd_nxt == PD_OFF) || !active_nxt;
		case (mode)
			`DPL_MODE_LD_IF: begin
				status_nxt = !if_act_s;
			end
			`DPL_MODE_LD_RF: begin
				status_nxt = !rf_act_s;
			end
			`DPL_MODE_LD_BOTH: begin
				status_nxt = !(if_act_s || rf_act_s);
			end
			`DPL_MODE_FASTLOCK: begin
				status_nxt = !rf_pump_boost;
			end
			default: begin
				status_nxt = 1'b0;
			end
		endcase
	end

	always @(posedge clk) begin
		if (reset) begin
			if_pump_current <= 3'h0;
			rf_pump_current <= 3'h0;
			if_pump_hiz <= 1'b1;
			rf_pump_hiz <= 1'b1;
			if_counter_hold <= 1'b1;
			rf_counter_hold <= 1'b1;
			if_div_resync <= 1'b0;
			rf_div_resync <= 1'b0;
			if_powered_down <= 1'b0;
			rf_powered_down <= 1'b0;
			reference_input_disable <= 1'b0;
			multiplexed_status_pin <= 1'b0;
			fast_settle_switch_pin <= 1'b0;
			fast_settle_switch_oe <= 1'b0;
			outputs_active <= 1'b0;
		end else if (clk_en) begin
			if_pump_current <= if_pump_current_nxt;
			rf_pump_current <= rf_pump_current_nxt;
			if_pump_hiz <= if_pump_hiz_nxt;
			rf_pump_hiz <= rf_pump_hiz_nxt;
			if_counter_hold <= if_counter_hold_nxt;
			rf_counter_hold <= rf_counter_hold_nxt;
			if_div_resync <= if_counter_hold && !if_counter_hold_nxt;
			rf_div_resync <= rf_counter_hold && !rf_counter_hold_nxt;
			if_powered_down <= (if_pd_nxt == PD_OFF);
			rf_powered_down <= (rf_pd_nxt == PD_OFF);
			reference_input_disable <= (if_pd_nxt == PD_OFF) &&
				(rf_pd_nxt == PD_OFF);
			multiplexed_status_pin <= status_nxt;
			fast_settle_switch_pin <= 1'b0;
			fast_settle_switch_oe <= if_pump_boost || rf_pump_boost;
			outputs_active <= active_nxt;
		end
	end

endmodule // dpl_control

`default_nettype wire

/* bench/dpl_host_model.sv */
// Purpose: Host side of the three-wire serial link
// Assumes: 320 ns serial clock, idle low between frames
// Notes: Data line shows the inverse of the last bit once released
`timescale 1ns/100ps
`default_nettype none
module dpl_host_model (
	output logic serial_clk,
	output logic serial_in,
	output logic load_strobe
);
	initial begin
		serial_clk = 1'b0;
		serial_in = 1'b0;
		load_strobe = 1'b0;
	end
	// Shifts one word, then pulses the strobe
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			serial_in = w[i];
			#160 serial_clk = 1'b1;
			#160 serial_clk = 1'b0;
		end
		serial_in = ~w[0];
		#120 load_strobe = 1'b1;
		#320 load_strobe = 1'b0;
		#200;
	endtask
endmodule // dpl_host_model
`default_nettype wire

/* bench/dpl_control_checker.sv */
// Purpose: Port-level assertions for dpl_control
// Assumes: Sees only top-level ports
// Notes: Bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module dpl_control_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic load_strobe,
	input wire logic [13:0] if_reference_divider,
	input wire logic if_pump_hiz,
	input wire logic if_counter_hold,
	input wire logic if_div_resync,
	input wire logic if_powered_down,
	input wire logic rf_pump_hiz,
	input wire logic rf_counter_hold,
	input wire logic rf_div_resync,
	input wire logic rf_powered_down,
	input wire logic reference_input_disable,
	input wire logic fast_settle_switch_pin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_FS_LOW: assert property (fast_settle_switch_pin == 1'b0)
		else $error("fast settle pin not low");
	AST_IF_PD_HIZ: assert property (if_powered_down |-> if_pump_hiz)
		else $error("if powered down with pump driving");
	AST_RF_PD_HIZ: assert property (rf_powered_down |-> rf_pump_hiz)
		else $error("rf powered down with pump driving");
	AST_IF_PD_ORDER: assert property ($rose(if_powered_down) |-> $past(if_pump_hiz))
		else $error("if powered down before pump three-state");
	AST_RF_PD_ORDER: assert property ($rose(rf_powered_down) |-> $past(rf_pump_hiz))
		else $error("rf powered down before pump three-state");
	AST_IF_PD_HOLD: assert property (if_powered_down |-> if_counter_hold)
		else $error("if powered down with counters free");
	AST_REF_OFF: assert property (reference_input_disable |->
		(if_powered_down || $past(if_powered_down)) && (rf_powered_down || $past(rf_powered_down)))
		else $error("reference disabled with a side running");
	AST_IF_RESYNC: assert property ($fell(if_counter_hold) |-> ##[0:1] if_div_resync)
		else $error("no if resync on hold release");
	AST_RF_RESYNC: assert property ($fell(rf_counter_hold) |-> ##[0:1] rf_div_resync)
		else $error("no rf resync on hold release");
	AST_STROBE: assert property ($changed(if_reference_divider) |->
		$past(load_strobe, 2) || $past(load_strobe, 3) || $past(load_strobe, 4))
		else $error("if divider changed without strobe");
	cover property (reference_input_disable);
	cover property (if_div_resync);
	cover property ($fell(rf_powered_down));
endmodule // dpl_control_checker
`default_nettype wire

/* bench/dpl_control_tb_top.sv */
// Purpose: Self-checking bench for dpl_control
// Assumes: Host model drives the serial pins
// Notes: Expected outputs queued per word, compared at strobe fall
`timescale 1ns/100ps
`default_nettype none
module dpl_control_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic ia = 1'b0;
	logic ra = 1'b0;
	wire serial_clk, serial_in, load_strobe;
	logic [13:0] ir, rr;
	logic [5:0] isw, rsw;
	logic [11:0] ipg, rpg;
	logic [1:0] ips, rps;
	logic [2:0] icu, rcu;
	logic ise, ihz, iho, ipd, rse, rhz, rho, rpd, rdis, mux, fsp, fso, act;
	logic [85:0] seen;
	logic [85:0] q[$];
	logic [23:0] lat[4];
	logic [3:0] wm;
	logic [31:0] seed = 32'h8848261E;
	logic [23:0] d;
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;
	assign seen = {ir, isw, ipg, ips, ise, icu, ihz, iho, ipd,
		rr, rsw, rpg, rps, rse, rcu, rhz, rho, rpd, rdis, mux, fso, act};
	dpl_host_model u_host (.serial_clk(serial_clk), .serial_in(serial_in),
		.load_strobe(load_strobe));
	dpl_control u_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .serial_clk(serial_clk),
		.serial_in(serial_in), .load_strobe(load_strobe), .if_pfd_active(ia),
		.rf_pfd_active(ra), .if_reference_divider(ir), .if_swallow_count(isw),
		.if_program_count(ipg), .if_prescale_sel(ips), .if_detector_sense(ise),
		.if_pump_current(icu), .if_pump_hiz(ihz), .if_counter_hold(iho),
		.if_div_resync(), .if_powered_down(ipd), .rf_reference_divider(rr),
		.rf_swallow_count(rsw), .rf_program_count(rpg), .rf_prescale_sel(rps),
		.rf_detector_sense(rse), .rf_pump_current(rcu), .rf_pump_hiz(rhz),
		.rf_counter_hold(rho), .rf_div_resync(), .rf_powered_down(rpd),
		.reference_input_disable(rdis), .multiplexed_status_pin(mux),
		.fast_settle_switch_pin(fsp), .fast_settle_switch_oe(fso), .outputs_active(act));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	always #20 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [40:0] side(input logic [23:0] r, f, input logic cr, c);
		return {r[15:2], f[7:2], f[19:8], f[21:20], r[17], f[23] ? 3'h7 : r[23:21],
			r[18] | cr | f[22] | !c, cr | f[22] | !c, f[22]};
	endfunction
	function automatic logic [85:0] expv();
		logic [3:0] m;
		logic st;
		m = {lat[2][20:19], lat[0][20:19]};
		case (m)
			4'h1: st = !ia;
			4'h2: st = !ra;
			4'h3: st = !(ia | ra);
			4'h7: st = !lat[3][23];
			default: st = 1'b0;
		endcase
		return {side(lat[0], lat[1], m == 4'h4 || m == 4'h6, &wm),
			side(lat[2], lat[3], m == 4'h5 || m == 4'h6, &wm),
			lat[1][22] & lat[3][22], st, lat[1][23] | lat[3][23], &wm};
	endfunction
	task automatic wr(input logic [1:0] s, input logic [23:0] v);
		@(posedge clk);
		#2;
		{ia, ra} = rnd();
		lat[s] = {v[23:2], s};
		wm[s] = 1'b1;
		q.push_back(expv());
		u_host.send(lat[s]);
	endtask
	task automatic chk(input string n, input logic [13:0] e, s);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Watcher and timeout
	// ----------------------------------------
	always @(negedge load_strobe) begin
		if (q.size() != 0) begin
			samples_checked++;
			if (seen !== q[0]) begin
				fails++;
				$display("[FAIL] outputs expected %h seen %h", q[0], seen);
			end
			void'(q.pop_front());
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		wm = 4'h0;
		lat = '{default: 24'h0};
		repeat (6) @(posedge clk);
		#2 reset = 1'b0;
		chk("reset", 5'h0C, {act, ihz, rhz, rpd, rdis});
		for (int i = 0; i < 4; i++) wr(i, rnd() & 24'h07FFFF);
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			wr(2, {d[23:21], i[3:2], d[18:0]});
			wr(0, {d[23:21], i[1:0], d[18:0]});
		end
		for (int i = 0; i < 4; i++) begin
			d = (rnd() & 24'h3FFFFF) | (i < 2 ? 24'h800000 : 24'h0);
			wr(i[0] ? 2'h1 : 2'h3, d);
		end
		wr(0, rnd() & 24'hE3FFFF);
		wr(1, (rnd() & 24'h3FFFFF) | 24'h400000);
		wr(2, (rnd() & 24'hE7FFFF) | 24'h040000);
		wr(3, (rnd() & 24'h3FFFFF) | 24'h400000);
		wr(0, rnd() & 24'hE7FFFF);
		wr(1, rnd() & 24'h3FFFFF);
		wr(0, (rnd() & 24'hE3FFFF) | 24'h040000);
		wr(1, (rnd() & 24'h3FFFFF) | 24'h400000);
		wr(2, rnd() & 24'hE3FFFF);
		wr(3, rnd() & 24'h3FFFFF);
		wr(3, (rnd() & 24'h3FFFFF) | 24'h400000);
		// Frozen clock enable: a full word must not reach the latches
		@(posedge clk);
		#2 clk_en = 1'b0;
		u_host.send({~lat[0][23:2], 2'h0});
		@(posedge clk);
		#2 clk_en = 1'b1;
		repeat (4) @(posedge clk);
		#2 chk("frozen", lat[0][15:2], ir);
		@(posedge clk);
		#2 reset = 1'b1;
		wm = 4'h0;
		lat = '{default: 24'h0};
		repeat (3) @(posedge clk);
		#2 reset = 1'b0;
		chk("rerun", 5'h0C, {act, ihz, rhz, rpd, rdis});
		final_report();
	end
endmodule // dpl_control_tb_top
bind dpl_control dpl_control_checker u_chk (.clk(clk), .reset(reset),
	.load_strobe(load_strobe), .if_reference_divider(if_reference_divider),
	.if_pump_hiz(if_pump_hiz), .if_counter_hold(if_counter_hold),
	.if_div_resync(if_div_resync), .if_powered_down(if_powered_down),
	.rf_pump_hiz(rf_pump_hiz), .rf_counter_hold(rf_counter_hold),
	.rf_div_resync(rf_div_resync), .rf_powered_down(rf_powered_down),
	.reference_input_disable(reference_input_disable),
	.fast_settle_switch_pin(fast_settle_switch_pin));
`default_nettype wire
